// ===== inc/lcd_pkg.sv
// shared constants and carrier types for the character display instruction decoder
`default_nettype none
package lcd_pkg;
	// clock and execution times
	localparam int CLK_NS       = 100;
	localparam int T_RAM_NS     = 43000;
	localparam int T_INSTR_NS   = 39000;
	localparam int T_LONG_NS    = 1530000;
	localparam int RAM_CYC_I    = (T_RAM_NS + CLK_NS - 1) / CLK_NS;
	localparam int INSTR_CYC_I  = (T_INSTR_NS + CLK_NS - 1) / CLK_NS;
	localparam int LONG_CYC_I   = (T_LONG_NS + CLK_NS - 1) / CLK_NS;
	localparam int BUSY_W       = 16;
	localparam logic [15:0] RAM_CYC   = 16'(RAM_CYC_I);
	localparam logic [15:0] INSTR_CYC = 16'(INSTR_CYC_I);
	localparam int BLINK_CYC_DEF = 4000;
	// instruction opcodes: highest set bit position
	localparam int BIT_CLEAR = 0;
	localparam int BIT_HOME  = 1;
	localparam int BIT_ENTRY = 2;
	localparam int BIT_DISP  = 3;
	localparam int BIT_SHIFT = 4;
	localparam int BIT_FUNC  = 5;
	localparam int BIT_GLYPH = 6;
	localparam int BIT_TEXT  = 7;
	// field positions
	localparam int F_SCROLL  = 0;
	localparam int F_UP      = 1;
	localparam int F_FLASH   = 0;
	localparam int F_CURSOR  = 1;
	localparam int F_SCREEN  = 2;
	localparam int F_RL      = 2;
	localparam int F_SC      = 3;
	localparam int F_TALL    = 2;
	localparam int F_ROWS    = 3;
	localparam int F_WIDTH   = 4;
	// text memory layout
	localparam logic [6:0] ROW1_LAST    = 7'h27;
	localparam logic [6:0] ROW2_BASE    = 7'h40;
	localparam logic [6:0] ROW2_LAST    = 7'h67;
	localparam logic [6:0] ONE_ROW_LAST = 7'h4f;
	localparam logic [6:0] ROW_LEN_TWO  = 7'h28;
	localparam logic [6:0] ROW_LEN_ONE  = 7'h50;
	localparam logic [6:0] ADDR_LAST    = 7'h7f;
	localparam logic [7:0] SPACE_CODE   = 8'h20;
	localparam int TEXT_WORDS  = 128;
	localparam int GLYPH_WORDS = 64;
	// carrier types
	typedef struct packed {
		logic       e;
		logic       register_select;
		logic       rw;
		logic [7:0] data;
	} host_pins_t;
	typedef struct packed {
		logic screen_on;
		logic cursor_visible;
		logic cursor_flash;
	} disp_ctrl_t;
	typedef struct packed {
		logic bus_width_sel;
		logic two_row;
		logic tall_glyph;
	} func_t;
	typedef struct packed {
		logic step_up;
		logic entry_scroll_enable;
	} entry_t;
endpackage
`default_nettype wire

// ===== hw/char_lcd_instruction_decoder.sv
// instruction decoder, address counter and host bus logic of a character display controller
// Notes on behaviour
// - scroll flag set: text writes shift display, left stepping up, right stepping down
// - display control: highest set bit DB3 loads screen, cursor, flash controls
// - screen off blanks display but keeps text memory contents
// - cursor control hides cursor only; step direction setting is kept
// - flash on alternates cursor cell between all pixels and character
// - shift instruction: 00 cursor left, 01 right, 10 display left, 11 right
// - display shift leaves address counter alone and moves no data
// - display shift applies to every row at once
// - two-row mode: cursor past first row end jumps to second row start
// - function set DB5: width bit high selects 8-bit bus, low 4-bit
// - 4-bit mode moves each byte as two nibbles on upper lines
// - row-count bit low one row, high two rows
// - glyph-height bit low 5x8, high 5x11
// - glyph address instruction loads 6-bit counter, targets glyph memory
// - text address instruction loads 7-bit counter, targets text memory
// - text addresses: one row 00-4f; two rows 00-27 and 40-67
// - status read returns busy on DB7 and counter below; host waits
// - data write stores byte in selected memory; counter steps after each access
// - first read without address set is invalid; second onward correct
// - cursor shift reloads output data register for text memory reads
// - read after write returns previously latched data, not new address
// - step-up bit high moves cursor right, address plus one
// - data write or read holds busy for 43us
`timescale 1ns/10ps
`default_nettype none
module char_lcd_instruction_decoder #(
	parameter int LONG_CYCLES = lcd_pkg::LONG_CYC_I,
	parameter int BLINK_CYCLES = lcd_pkg::BLINK_CYC_DEF
) (
	input  wire logic                clk,
	input  wire logic                nrst,
	input  wire lcd_pkg::host_pins_t host_pins,
	output logic [7:0]               host_bus_lines_o,
	output logic [7:0]               host_bus_lines_oe,
	output logic                     busy_flag,
	output logic [6:0]               address_counter,
	output lcd_pkg::disp_ctrl_t      disp_ctrl,
	output lcd_pkg::func_t           func,
	output lcd_pkg::entry_t          entry,
	output logic [6:0]               view_offset,
	output logic                     display_visible,
	output logic                     cursor_shown,
	output logic                     cursor_cell_lit,
	input  wire logic [6:0]          scan_addr,
	output logic [7:0]               scan_char,
	input  wire logic [5:0]          scan_glyph_addr,
	output logic [7:0]               scan_glyph
);
	if (LONG_CYCLES < lcd_pkg::TEXT_WORDS || LONG_CYCLES >= (1 << lcd_pkg::BUSY_W)) begin : g_bad_long
		$error("LONG_CYCLES must cover the clear walk and fit the busy counter");
	end
	if (BLINK_CYCLES < 2 || BLINK_CYCLES >= (1 << lcd_pkg::BUSY_W)) begin : g_bad_blink
		$error("BLINK_CYCLES out of range");
	end
	localparam logic [15:0] LONG_CYC  = 16'(LONG_CYCLES);
	localparam logic [15:0] BLINK_CYC = 16'(BLINK_CYCLES);

	lcd_pkg::host_pins_t pin_s1_q, pin_s2_q, pin_s3_q, pin_f_q;
	logic                e_prev_q;
	logic                phase_q;
	logic [3:0]          nib_hi_q;
	logic [7:0]          rd_byte_q;
	logic [7:0]          out_q;
	logic [6:0]          ac_q;
	logic                tgt_text_q;
	logic [6:0]          shift_q;
	logic [15:0]         busy_q;
	logic                load_q;
	logic [7:0]          dout_q;
	logic                clearing_q;
	logic [6:0]          clr_idx_q;
	logic [15:0]         blink_q;
	logic                flash_ph_q;
	lcd_pkg::disp_ctrl_t disp_q;
	lcd_pkg::func_t      func_q;
	lcd_pkg::entry_t     entry_q;
	logic [7:0]          text_mem [lcd_pkg::TEXT_WORDS];
	logic [7:0]          glyph_mem [lcd_pkg::GLYPH_WORDS];

	logic       e_rise, e_fall, bus8, byte_done, take;
	logic       take_instr, take_wdata, take_rdata;
	logic [7:0] cmd, rd_val;
	logic       is_clear, is_home, is_entry, is_disp, is_shift, is_func, is_glyph, is_text;
	logic [6:0] ac_step, shift_left, shift_right, row_len;
	logic       text_we;
	logic [6:0] text_waddr;
	logic [7:0] text_wdata;

	// step through text addresses, skipping the gap between rows in two-row mode
	function automatic logic [6:0] step_text(input logic [6:0] a, input logic up, input logic two);
		logic [6:0] r;
		r = a;
		if (two) begin
			if (up) r = (a == lcd_pkg::ROW1_LAST) ? lcd_pkg::ROW2_BASE :
				(a == lcd_pkg::ROW2_LAST) ? 7'h00 : 7'(a + 7'h01);
			else r = (a == 7'h00) ? lcd_pkg::ROW2_LAST :
				(a == lcd_pkg::ROW2_BASE) ? lcd_pkg::ROW1_LAST : 7'(a - 7'h01);
		end else begin
			if (up) r = (a >= lcd_pkg::ONE_ROW_LAST) ? 7'h00 : 7'(a + 7'h01);
			else r = (a == 7'h00) ? lcd_pkg::ONE_ROW_LAST : 7'(a - 7'h01);
		end
		return r;
	endfunction

	// three-stage pin synchroniser; a bit changes once stages two and three agree
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			pin_s1_q <= '0;
			pin_s2_q <= '0;
			pin_s3_q <= '0;
			pin_f_q  <= '0;
		end else begin
			pin_s1_q <= host_pins;
			pin_s2_q <= pin_s1_q;
			pin_s3_q <= pin_s2_q;
			pin_f_q  <= (pin_s2_q & pin_s3_q) | (pin_f_q & (pin_s2_q | pin_s3_q));
		end
	end

	// enable edges, transfer framing and instruction decode
	assign e_rise     = pin_f_q.e & ~e_prev_q;
	assign e_fall     = ~pin_f_q.e & e_prev_q;
	assign bus8       = func_q.bus_width_sel;
	assign byte_done  = e_fall & (bus8 | phase_q);
	assign take       = byte_done & (busy_q == 16'h0000);
	assign take_instr = take & ~pin_f_q.register_select & ~pin_f_q.rw;
	assign take_wdata = take & pin_f_q.register_select & ~pin_f_q.rw;
	assign take_rdata = take & pin_f_q.register_select & pin_f_q.rw;
	assign cmd        = bus8 ? pin_f_q.data : {nib_hi_q, pin_f_q.data[7:4]};
	assign is_clear   = (cmd >> lcd_pkg::BIT_CLEAR) == 8'h01;
	assign is_home    = (cmd >> lcd_pkg::BIT_HOME) == 8'h01;
	assign is_entry   = (cmd >> lcd_pkg::BIT_ENTRY) == 8'h01;
	assign is_disp    = (cmd >> lcd_pkg::BIT_DISP) == 8'h01;
	assign is_shift   = (cmd >> lcd_pkg::BIT_SHIFT) == 8'h01;
	assign is_func    = (cmd >> lcd_pkg::BIT_FUNC) == 8'h01;
	assign is_glyph   = (cmd >> lcd_pkg::BIT_GLYPH) == 8'h01;
	assign is_text    = (cmd >> lcd_pkg::BIT_TEXT) == 8'h01;
	assign rd_val     = pin_f_q.register_select ? dout_q : {busy_flag, ac_q};

	// next address and scroll positions
	assign ac_step     = tgt_text_q ? step_text(ac_q, entry_q.step_up, func_q.two_row)
		: {1'b0, 6'(ac_q[5:0] + (entry_q.step_up ? 6'h01 : 6'h3f))};
	assign row_len     = func_q.two_row ? lcd_pkg::ROW_LEN_TWO : lcd_pkg::ROW_LEN_ONE;
	assign shift_left  = (shift_q + 7'h01 >= row_len) ? 7'h00 : 7'(shift_q + 7'h01);
	assign shift_right = (shift_q == 7'h00) ? 7'(row_len - 7'h01) : 7'(shift_q - 7'h01);

	// nibble phase, upper nibble capture and read data drive
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			e_prev_q  <= 1'b0;
			phase_q   <= 1'b0;
			nib_hi_q  <= '0;
			rd_byte_q <= '0;
			out_q     <= '0;
		end else begin
			e_prev_q <= pin_f_q.e;
			if (e_fall) begin
				phase_q <= bus8 ? 1'b0 : ~phase_q;
				if (!phase_q) nib_hi_q <= pin_f_q.data[7:4];
			end
			if (e_rise && pin_f_q.rw) begin
				if (!phase_q) rd_byte_q <= rd_val;
				if (bus8) out_q <= rd_val;
				else if (phase_q) out_q <= {rd_byte_q[3:0], 4'h0};
				else out_q <= {rd_val[7:4], 4'h0};
			end
		end
	end
	assign host_bus_lines_o  = out_q;
	assign host_bus_lines_oe = {{4{pin_f_q.e & pin_f_q.rw}}, {4{pin_f_q.e & pin_f_q.rw & bus8}}};

	// instruction execution: counter, target, control bits and scroll
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			ac_q       <= '0;
			tgt_text_q <= 1'b1;
			shift_q    <= '0;
			load_q     <= 1'b0;
			clearing_q <= 1'b0;
			clr_idx_q  <= '0;
			disp_q     <= '0;
			func_q     <= '{bus_width_sel: 1'b1, two_row: 1'b0, tall_glyph: 1'b0};
			entry_q    <= '{step_up: 1'b1, entry_scroll_enable: 1'b0};
		end else begin
			load_q <= 1'b0;
			if (clearing_q) begin
				clr_idx_q <= 7'(clr_idx_q + 7'h01);
				if (clr_idx_q == lcd_pkg::ADDR_LAST) clearing_q <= 1'b0;
			end
			if (take_instr) begin
				if (is_text) begin
					ac_q       <= cmd[6:0];
					tgt_text_q <= 1'b1;
					load_q     <= 1'b1;
				end else if (is_glyph) begin
					ac_q       <= {1'b0, cmd[5:0]};
					tgt_text_q <= 1'b0;
					load_q     <= 1'b1;
				end else if (is_func) begin
					func_q <= '{bus_width_sel: cmd[lcd_pkg::F_WIDTH],
						two_row: cmd[lcd_pkg::F_ROWS],
						tall_glyph: cmd[lcd_pkg::F_TALL]};
				end else if (is_shift) begin
					if (!cmd[lcd_pkg::F_SC]) begin
						ac_q   <= step_text(ac_q, cmd[lcd_pkg::F_RL], func_q.two_row);
						load_q <= tgt_text_q;
					end else begin
						shift_q <= cmd[lcd_pkg::F_RL] ? shift_right : shift_left;
					end
				end else if (is_disp) begin
					disp_q <= '{screen_on: cmd[lcd_pkg::F_SCREEN],
						cursor_visible: cmd[lcd_pkg::F_CURSOR],
						cursor_flash: cmd[lcd_pkg::F_FLASH]};
				end else if (is_entry) begin
					entry_q <= '{step_up: cmd[lcd_pkg::F_UP],
						entry_scroll_enable: cmd[lcd_pkg::F_SCROLL]};
				end else if (is_home || is_clear) begin
					ac_q       <= '0;
					tgt_text_q <= 1'b1;
					shift_q    <= '0;
					if (is_clear) begin
						entry_q.step_up <= 1'b1;
						clearing_q      <= 1'b1;
						clr_idx_q       <= '0;
					end
				end
			end
			if (take_wdata) begin
				ac_q <= ac_step;
				if (tgt_text_q && entry_q.entry_scroll_enable)
					shift_q <= entry_q.step_up ? shift_left : shift_right;
			end
			if (take_rdata) begin
				ac_q   <= ac_step;
				load_q <= 1'b1;
			end
		end
	end

	// busy timer: every accepted instruction and data transfer holds the flag for its execution time; status reads do not
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			busy_q <= '0;
		end else if (take_wdata || take_rdata) begin
			busy_q <= lcd_pkg::RAM_CYC;
		end else if (take_instr) begin
			busy_q <= (is_clear || is_home) ? LONG_CYC : lcd_pkg::INSTR_CYC;
		end else if (busy_q != 16'h0000) begin
			busy_q <= 16'(busy_q - 16'h0001);
		end
	end
	assign busy_flag       = busy_q != 16'h0000;
	assign address_counter = ac_q;

	// output data register follows address sets, cursor shifts with text memory targeted, and reads, not writes
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			dout_q <= '0;
		end else if (load_q) begin
			dout_q <= tgt_text_q ? text_mem[ac_q] : glyph_mem[ac_q[5:0]];
		end
	end

	// memory write ports; the clear walk fills text memory with spaces
	assign text_we    = clearing_q | (take_wdata & tgt_text_q);
	assign text_waddr = clearing_q ? clr_idx_q : ac_q;
	assign text_wdata = clearing_q ? lcd_pkg::SPACE_CODE : cmd;
	always_ff @(posedge clk) begin
		if (text_we) text_mem[text_waddr] <= text_wdata;
		if (take_wdata && !tgt_text_q) glyph_mem[ac_q[5:0]] <= cmd;
		scan_char  <= text_mem[scan_addr];
		scan_glyph <= glyph_mem[scan_glyph_addr];
	end

	// cursor flash phase
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			blink_q    <= '0;
			flash_ph_q <= 1'b0;
		end else if (blink_q == 16'(BLINK_CYC - 16'h0001)) begin
			blink_q    <= '0;
			flash_ph_q <= ~flash_ph_q;
		end else begin
			blink_q <= 16'(blink_q + 16'h0001);
		end
	end

	// display-side controls; blanking never touches memory
	assign disp_ctrl       = disp_q;
	assign func            = func_q;
	assign entry           = entry_q;
	assign view_offset     = shift_q;
	assign display_visible = disp_q.screen_on;
	assign cursor_shown    = disp_q.screen_on & disp_q.cursor_visible;
	assign cursor_cell_lit = disp_q.screen_on & disp_q.cursor_flash & flash_ph_q;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);

	a_ram_busy_load: assert property ((take_wdata || take_rdata) |=> busy_q == lcd_pkg::RAM_CYC)
		else $error("data access did not load RAM busy time");
	a_busy_countdown: assert property (busy_flag && !take |=> busy_q == 16'($past(busy_q) - 16'h0001))
		else $error("busy timer not counting down");
	a_disp_ctrl_load: assert property (take_instr && is_disp |=> disp_q == $past(cmd[2:0]))
		else $error("display control bits not loaded");
	a_shift_keeps_ac: assert property (take_instr && is_shift && cmd[lcd_pkg::F_SC] |=> $stable(ac_q))
		else $error("display shift changed the counter");
	a_row_wrap: assert property (take_instr && is_shift && !cmd[lcd_pkg::F_SC] && cmd[lcd_pkg::F_RL]
		&& func_q.two_row && ac_q == lcd_pkg::ROW1_LAST |=> ac_q == lcd_pkg::ROW2_BASE)
		else $error("cursor did not wrap to second row");
	a_scroll_write: assert property (take_wdata && tgt_text_q && entry_q.entry_scroll_enable
		&& entry_q.step_up |=> shift_q == $past(shift_left))
		else $error("text write with scroll did not shift left");
	a_glyph_no_scroll: assert property (take_wdata && !tgt_text_q |=> $stable(shift_q))
		else $error("glyph write shifted the display");
	a_glyph_addr: assert property (take_instr && is_glyph |=> ac_q == {1'b0, $past(cmd[5:0])}
		&& !tgt_text_q)
		else $error("glyph address not loaded");
	a_status_read: assert property (e_rise && pin_f_q.rw && !pin_f_q.register_select && bus8
		|=> out_q == {$past(busy_flag), $past(ac_q)})
		else $error("status read value wrong");
	a_write_no_load: assert property (take_wdata |=> ##1 $stable(dout_q))
		else $error("write reloaded the output data register");
	a_text_addr: assert property (take_instr && is_text |=> ac_q == $past(cmd[6:0]) && tgt_text_q)
		else $error("text address not loaded");
	a_func_load: assert property (take_instr && is_func
		|=> func_q == $past(cmd[lcd_pkg::F_WIDTH:lcd_pkg::F_TALL]))
		else $error("function set bits not loaded");
	a_read_step: assert property (take_rdata |=> ac_q == $past(ac_step))
		else $error("read did not step the counter");
	a_read_no_scroll: assert property (take_rdata |=> $stable(shift_q))
		else $error("data read shifted the display");

	c_text_write: cover property (take_wdata && tgt_text_q);
	c_nibble_instr: cover property (take_instr && !bus8);
	c_display_shift: cover property (take_instr && is_shift && cmd[lcd_pkg::F_SC]);
	c_data_read: cover property (take_rdata ##[1:500] e_rise && pin_f_q.rw);
endmodule // char_lcd_instruction_decoder
`default_nettype wire

// ===== testbench/host_model.sv
// host processor model that drives the display controller bus pins
`timescale 1ns/10ps
`default_nettype none
module host_model (
	input  wire logic          clk,
	input  wire logic [7:0]    bus_o,
	input  wire logic [7:0]    bus_oe,
	output var lcd_pkg::host_pins_t pins
);
	logic       narrow;
	logic [7:0] last_oe;
	// one enable strobe: hold 8 clk, sample read data, drop, let the filter settle
	task automatic strobe(input logic rs, rw, input logic [7:0] d, output logic [7:0] r);
		@(posedge clk);
		#1 pins = {1'b1, rs, rw, rw ? ~pins.data : d};
		repeat (8) @(posedge clk);
		r = bus_o;
		last_oe = bus_oe; // line enables seen while the read data stands
		#1 pins.e = 1'b0;
		repeat (8) @(posedge clk);
		#1 pins.data = ~pins.data; // released lines carry no stale value
	endtask
	// one byte, split into two upper-line nibbles in narrow mode
	task automatic xfer(input logic rs, rw, input logic [7:0] d, output logic [7:0] r);
		logic [7:0] h;
		logic [7:0] l;
		if (!narrow) begin
			strobe(rs, rw, d, r);
		end else begin
			strobe(rs, rw, {d[7:4], 4'h0}, h);
			strobe(rs, rw, {d[3:0], 4'h0}, l);
			r = {h[7:4], l[7:4]};
		end
	endtask
	// poll status until not busy; the strobe spacing covers the half period wait
	task automatic idle();
		logic [7:0] s;
		s = 8'h80;
		for (int i = 0; i < 200 && s[7] !== 1'b0; i++) xfer(1'b0, 1'b1, 8'h00, s);
	endtask
	task automatic send(input logic rs, input logic [7:0] d);
		logic [7:0] r;
		idle();
		xfer(rs, 1'b0, d, r);
	endtask
	task automatic fetch(output logic [7:0] r);
		idle();
		xfer(1'b1, 1'b1, 8'h00, r);
	endtask
	initial begin
		narrow = 1'b0;
		last_oe = '0;
		pins = '0;
	end
endmodule // host_model
`default_nettype wire

// ===== testbench/char_lcd_instruction_decoder_tb.sv
// self-checking bench for the character display instruction decoder
`timescale 1ns/10ps
`default_nettype none
module char_lcd_instruction_decoder_tb;
	logic                clk;
	logic                nrst;
	lcd_pkg::host_pins_t pins;
	logic [7:0]          bus_o;
	logic [7:0]          bus_oe;
	logic                busy;
	logic [6:0]          ac;
	lcd_pkg::disp_ctrl_t disp;
	lcd_pkg::func_t      func;
	lcd_pkg::entry_t     entry;
	logic [6:0]          offs;
	logic                vis;
	logic                cur;
	logic                lit;
	logic [6:0]          saddr = 7'h00;
	logic [7:0]          schar;
	logic [5:0]          gaddr = 6'h00;
	logic [7:0]          sglyph;
	int                  miscompares = 0;
	int                  n_tests = 0;
	int                  run = 0;
	int                  last_run = 0;
	char_lcd_instruction_decoder #(.LONG_CYCLES(200), .BLINK_CYCLES(8)) uut (
		.clk(clk), .nrst(nrst), .host_pins(pins), .host_bus_lines_o(bus_o),
		.host_bus_lines_oe(bus_oe), .busy_flag(busy), .address_counter(ac),
		.disp_ctrl(disp), .func(func), .entry(entry), .view_offset(offs),
		.display_visible(vis), .cursor_shown(cur), .cursor_cell_lit(lit),
		.scan_addr(saddr), .scan_char(schar), .scan_glyph_addr(gaddr), .scan_glyph(sglyph)
	);
	host_model host (.clk(clk), .bus_o(bus_o), .bus_oe(bus_oe), .pins(pins));
	// clock generator
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	// length of the last busy period in cycles
	always @(posedge clk) begin
		if (busy === 1'b1) begin
			run <= run + 1;
		end else begin
			if (run != 0) last_run <= run;
			run <= 0;
		end
	end
	task automatic chk(input logic [15:0] got, exp);
		n_tests++;
		if (got !== exp) begin
			miscompares++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic scan(input logic [6:0] a, input logic [7:0] exp);
		@(posedge clk);
		#1 saddr = a;
		repeat (2) @(posedge clk);
		chk(schar, exp);
	endtask
	task automatic t_ctrl();
		for (int i = 0; i < 8; i++) begin
			host.send(1'b0, 8'h08 | 8'(i));
			chk(disp, 16'(i));
			chk({vis, cur}, {i[2], i[2] & i[1]});
		end
		chk(entry, 16'h0002);
		$display("t_ctrl done");
	endtask
	task automatic t_rw();
		logic [7:0] r;
		host.send(1'b0, 8'h85);
		host.send(1'b1, 8'ha1);
		host.send(1'b1, 8'hb2);
		host.xfer(1'b0, 1'b1, 8'h00, r);
		chk(r, 16'h0087);
		chk(host.last_oe, 16'h00ff);
		chk(bus_oe, 16'h0000);
		scan(7'h05, 8'ha1);
		scan(7'h06, 8'hb2);
		host.send(1'b0, 8'h85);
		host.send(1'b1, 8'hc3);
		host.fetch(r);
		chk(r, 16'h00a1);
		host.send(1'b0, 8'h85);
		host.fetch(r);
		chk(r, 16'h00c3);
		host.fetch(r);
		chk(r, 16'h00b2);
		host.idle();
		chk(16'(last_run), lcd_pkg::RAM_CYC);
		$display("t_rw done");
	endtask
	task automatic t_shift();
		logic [7:0] r;
		host.send(1'b0, 8'h90);
		host.send(1'b0, 8'h10);
		chk(ac, 16'h000f);
		host.send(1'b0, 8'h14);
		chk(ac, 16'h0010);
		host.send(1'b0, 8'h18);
		chk({offs, 1'b0, ac}, 16'h0110);
		host.send(1'b0, 8'h1c);
		chk({offs, 1'b0, ac}, 16'h0010);
		host.send(1'b0, 8'h84);
		host.send(1'b0, 8'h14);
		host.fetch(r);
		chk(r, 16'h00c3);
		$display("t_shift done");
	endtask
	task automatic t_scroll();
		logic [7:0] r;
		host.send(1'b0, 8'h07);
		host.send(1'b0, 8'h80);
		host.send(1'b1, 8'h41);
		chk(offs, 16'h0001);
		host.fetch(r);
		chk(offs, 16'h0001);
		host.send(1'b0, 8'h05);
		host.send(1'b1, 8'h42);
		chk({offs, 1'b0, ac}, 16'h0001);
		host.send(1'b0, 8'h40);
		host.send(1'b1, 8'h0a);
		chk(offs, 16'h0000);
		host.send(1'b0, 8'h06);
		$display("t_scroll done");
	endtask
	task automatic t_rows();
		host.send(1'b0, 8'h38);
		chk(func, 16'h0006);
		host.send(1'b0, 8'ha7);
		host.send(1'b0, 8'h14);
		chk(ac, 16'h0040);
		host.send(1'b0, 8'h3c);
		chk(func, 16'h0007);
		host.send(1'b0, 8'h30);
		$display("t_rows done");
	endtask
	task automatic t_glyph();
		logic [7:0] r;
		host.send(1'b0, 8'h7e);
		host.send(1'b1, 8'h15);
		chk(ac, 16'h003f);
		@(posedge clk);
		#1 gaddr = 6'h3e;
		repeat (2) @(posedge clk);
		chk(sglyph, 16'h0015);
		host.send(1'b0, 8'h7e);
		host.fetch(r);
		chk(r, 16'h0015);
		host.send(1'b0, 8'h80); // leave glyph target before any display shift
		$display("t_glyph done");
	endtask
	// display shift, return home, blanking and clear
	task automatic t_home();
		host.send(1'b0, 8'h18);
		chk({offs, 1'b0, ac}, 16'h0100);
		host.send(1'b0, 8'h02);
		host.send(1'b1, 8'h5b);
		chk({offs, 1'b0, ac}, 16'h0001);
		host.send(1'b0, 8'h08);
		scan(7'h00, 8'h5b);
		host.send(1'b0, 8'h04);
		host.send(1'b0, 8'h01);
		chk({entry, offs, ac}, 16'h8000);
		scan(7'h00, lcd_pkg::SPACE_CODE);
		$display("t_home done");
	endtask
	task automatic t_nib();
		logic [7:0] r;
		host.send(1'b0, 8'h20);
		chk(func, 16'h0000);
		host.narrow = 1'b1;
		host.send(1'b0, 8'h88);
		host.send(1'b1, 8'h5a);
		scan(7'h08, 8'h5a);
		host.send(1'b0, 8'h88);
		host.fetch(r);
		chk(r, 16'h005a);
		chk(host.last_oe, 16'h00f0);
		host.send(1'b0, 8'h30);
		host.narrow = 1'b0;
		chk(func, 16'h0004);
		$display("t_nib done");
	endtask
	task automatic t_flash();
		int n;
		n = 0;
		host.send(1'b0, 8'h0d);
		repeat (40) @(posedge clk) n += (lit === 1'b1);
		chk(n > 0 && n < 40, 16'h0001);
		host.send(1'b0, 8'h0c);
		n = 0;
		repeat (40) @(posedge clk) n += (lit !== 1'b0);
		chk(16'(n), 16'h0000);
		$display("t_flash done");
	endtask
	task automatic finish_test();
		$display("tests=%0d mismatches=%0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	// watchdog sized well above the expected run
	initial begin
		#(80000 * 100);
		miscompares++;
		finish_test();
	end
	// main sequence
	initial begin
		nrst = 1'b0;
		repeat (16) @(posedge clk);
		#1 nrst = 1'b1;
		repeat (4) @(posedge clk);
		t_ctrl();
		t_rw();
		t_shift();
		t_scroll();
		t_rows();
		t_glyph();
		t_home();
		t_nib();
		t_flash();
		finish_test();
	end
endmodule // char_lcd_instruction_decoder_tb
`default_nettype wire
